/* File: logic/mps_defs.vh */
// constants shared by the phase sequencer design files
`ifndef MPS_DEFS_VH
`define MPS_DEFS_VH
`define MPS_CLK_MHZ         200
`define MPS_RST_TIME_US     2000
`define MPS_RST_CYC         (`MPS_RST_TIME_US * `MPS_CLK_MHZ)
`define MPS_RESTORE_TIME_US 4000
`define MPS_RESTORE_CYC     (`MPS_RESTORE_TIME_US * `MPS_CLK_MHZ)
`define MPS_TON_DLY_RST     16'h0000
`define MPS_VOUT_READ_EXT   8'hFF
// phase strap codes from the strap comparator
`define MPS_PH_OPEN         3'h0
`define MPS_PH_GND          3'h1
`define MPS_PH_33K          3'h2
`define MPS_PH_13K          3'h3
`define MPS_PH_5K1          3'h4
// protection and reference strap codes: open,33k,20k,13k,8.2k,5.1k,2.7k,gnd
`define MPS_ST_OPEN         3'h0
`define MPS_ST_33K          3'h1
`define MPS_ST_20K          3'h2
`define MPS_ST_13K          3'h3
`define MPS_ST_8K2          3'h4
`define MPS_ST_2K7          3'h6
// tri-level output encoding
`define MPS_PWM_FLOAT       2'h0
`define MPS_PWM_HIGH        2'h1
`define MPS_PWM_LOW         2'h2
`define MPS_NPH             6
`endif

/* File: logic/mps_strap_decode.v */
// strap decoder: phase count, protection and reference options
`timescale 1ns/1ps
`include "mps_defs.vh"
module mps_strap_decode (
    input  wire [2:0] phase_strap,
    input  wire [2:0] protection_strap,
    input  wire [2:0] reference_strap,
    output reg  [2:0] phase_count,
    output reg        prot_enable,
    output reg        ovp_latch,
    output reg        fault_latch,
    output reg        ext_ref_sel,
    output reg        psi_func_sel,
    output reg        thermal_option_b
);
    always @*
    begin
        case (phase_strap)
            `MPS_PH_OPEN: phase_count = 3'd6;
            `MPS_PH_GND:  phase_count = 3'd4;
            `MPS_PH_33K:  phase_count = 3'd3;
            `MPS_PH_13K:  phase_count = 3'd2;
            `MPS_PH_5K1:  phase_count = 3'd1;
            default:      phase_count = 3'd6;
        endcase
        prot_enable = (protection_strap < `MPS_ST_8K2);
        ovp_latch   = (protection_strap == `MPS_ST_20K)
                    | (protection_strap == `MPS_ST_13K);
        fault_latch = (protection_strap == `MPS_ST_33K)
                    | (protection_strap == `MPS_ST_13K)
                    | (protection_strap == `MPS_ST_8K2);
        ext_ref_sel      = (reference_strap >= `MPS_ST_8K2);
        psi_func_sel     = (reference_strap >= `MPS_ST_20K);
        thermal_option_b = (reference_strap == `MPS_ST_33K)
                         | (reference_strap == `MPS_ST_13K)
                         | (reference_strap == `MPS_ST_8K2);
    end
endmodule // mps_strap_decode

/* File: logic/mps_pwm_drive.v */
// per-phase tri-level output stage with gating
`timescale 1ns/1ps
`include "mps_defs.vh"
module mps_pwm_drive (
    input  wire       mclk,
    input  wire       arst_n,
    input  wire       run,
    input  wire [2:0] active_count,
    input  wire [5:0] pwm_in,
    output reg  [5:0] pwm_hi_on_q,
    output reg  [5:0] pwm_lo_on_q
);
    genvar i;
    generate
        for (i = 0; i < `MPS_NPH; i = i + 1)
        begin : g_ph
            wire en = run && (active_count > i);
            always @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    pwm_hi_on_q[i] <= 1'b0;
                    pwm_lo_on_q[i] <= 1'b0;
                end
                else
                begin
                    // both switches off leaves the pin at mid-level
                    pwm_hi_on_q[i] <= en & pwm_in[i];
                    pwm_lo_on_q[i] <= en & ~pwm_in[i];
                end
            end
        end
    endgenerate
endmodule // mps_pwm_drive

/* File: logic/mps_sequencer.v */
// multi-phase controller power sequencer and configuration
`timescale 1ns/1ps
`include "mps_defs.vh"
module mps_sequencer #(
    parameter RST_CYC     = `MPS_RST_CYC,
    parameter RESTORE_CYC = `MPS_RESTORE_CYC
) (
    input  wire        mclk,
    input  wire        arst_n,
    input  wire        enable_above_th,
    input  wire        undervoltage_lockout,
    input  wire        vcc_ok,
    input  wire        driver_supply_ok,
    input  wire [2:0]  phase_strap,
    input  wire [2:0]  protection_strap,
    input  wire [2:0]  reference_strap,
    input  wire        turn_on_delay_cmd_wr,
    input  wire [15:0] turn_on_delay_cmd_data,
    input  wire        vout_cmd_wr,
    input  wire [7:0]  vout_cmd_data,
    input  wire [7:0]  boot_target,
    input  wire [7:0]  vout_measured,
    input  wire        ref_reached,
    input  wire        soft_step,
    input  wire        power_good_flag,
    input  wire        boot_restore_n,
    input  wire [5:0]  pwm_in,
    output reg  [5:0]  pwm_hi_on_q,
    output reg  [5:0]  pwm_lo_on_q,
    output reg  [7:0]  target_q,
    output reg  [7:0]  dac_q,
    output reg  [7:0]  vout_read_q,
    output reg         ramp_active_q,
    output reg         soft_start_done_q,
    output reg  [2:0]  phase_count_q,
    output reg         prot_enable_q,
    output reg         ovp_latch_q,
    output reg         fault_latch_q,
    output reg         ext_ref_sel_q,
    output reg         psi_func_sel_q,
    output reg         thermal_option_a_q,
    output reg         single_phase_state_q,
    output reg  [15:0] turn_on_delay_cmd_q
);
    localparam S_OFF   = 3'd0;
    localparam S_RST   = 3'd1;
    localparam S_DLY   = 3'd2;
    localparam S_RAMP  = 3'd3;
    localparam S_RUN   = 3'd4;
    localparam [31:0] RST_LAST = RST_CYC - 1;
    localparam [31:0] RES_LAST = RESTORE_CYC - 1;

    reg  [2:0]  state_q;
    reg  [31:0] cnt_q;
    reg  [31:0] restore_cnt_q;
    wire [2:0]  dec_phase;
    wire        dec_prot;
    wire        dec_ovpl;
    wire        dec_fltl;
    wire        dec_ext;
    wire        dec_psi;
    wire        dec_otb;
    wire        psi_level = boot_restore_n;
    // pin 27 is shared: the same wire is restore or power saving
    wire        go = enable_above_th & ~undervoltage_lockout;
    wire        run = (state_q == S_RAMP) | (state_q == S_RUN);
    wire [2:0]  active_n = single_phase_state_q ? 3'd1 : phase_count_q;
    // soft start ends at the reference when it is external, otherwise
    // when the internal ramp meets the target
    wire        ramp_done = ext_ref_sel_q ? ref_reached
                                          : (dac_q == target_q);
    // any high level on the pin restarts the restore count
    wire        restore_hit = (restore_cnt_q >= RES_LAST);

    // straps decode all the time; the state machine picks when to latch
    mps_strap_decode u_dec (
        .phase_strap      (phase_strap),
        .protection_strap (protection_strap),
        .reference_strap  (reference_strap),
        .phase_count      (dec_phase),
        .prot_enable      (dec_prot),
        .ovp_latch        (dec_ovpl),
        .fault_latch      (dec_fltl),
        .ext_ref_sel      (dec_ext),
        .psi_func_sel     (dec_psi),
        .thermal_option_b (dec_otb)
    );

    // gate on go and the driver supply here too, so either loss floats
    // the pins one edge later instead of waiting for the state machine
    mps_pwm_drive u_drv (
        .mclk         (mclk),
        .arst_n       (arst_n),
        .run          (run & go & driver_supply_ok),
        .active_count (active_n),
        .pwm_in       (pwm_in),
        .pwm_hi_on_q  (pwm_hi_on_q),
        .pwm_lo_on_q  (pwm_lo_on_q)
    );

    // the delay survives a disable, only reset clears it, so a value
    // written while off is used at the next start
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            turn_on_delay_cmd_q <= `MPS_TON_DLY_RST;
        end
        else if (turn_on_delay_cmd_wr)
        begin
            turn_on_delay_cmd_q <= turn_on_delay_cmd_data;
        end
    end

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q            <= S_OFF;
            cnt_q              <= 32'h0000_0000;
            phase_count_q      <= 3'd6;
            prot_enable_q      <= 1'b0;
            ovp_latch_q        <= 1'b0;
            fault_latch_q      <= 1'b0;
            ext_ref_sel_q      <= 1'b0;
            psi_func_sel_q     <= 1'b0;
            thermal_option_a_q <= 1'b1;
            ramp_active_q      <= 1'b0;
            soft_start_done_q  <= 1'b0;
        end
        else if (!go)
        begin
            // shutdown is immediate, whatever state the sequencer is in
            state_q           <= S_OFF;
            cnt_q             <= 32'h0000_0000;
            ramp_active_q     <= 1'b0;
            soft_start_done_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                S_OFF:
                begin
                    phase_count_q      <= dec_phase;
                    prot_enable_q      <= dec_prot;
                    ovp_latch_q        <= dec_ovpl & dec_prot;
                    fault_latch_q      <= dec_fltl;
                    ext_ref_sel_q      <= dec_ext;
                    psi_func_sel_q     <= dec_psi;
                    thermal_option_a_q <= ~dec_otb;
                    // straps follow the pins until the supply is good
                    if (vcc_ok)
                    begin
                        state_q <= S_RST;
                        cnt_q   <= 32'h0000_0000;
                    end
                end
                S_RST:
                begin
                    if (cnt_q >= RST_LAST)
                    begin
                        state_q <= S_DLY;
                        cnt_q   <= 32'h0000_0000;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 32'd1;
                    end
                end
                S_DLY:
                begin
                    if (cnt_q >= {16'h0000, turn_on_delay_cmd_q})
                    begin
                        // park here until the driver supply is up, so
                        // the ramp never starts into unpowered stages
                        if (driver_supply_ok)
                        begin
                            state_q       <= S_RAMP;
                            ramp_active_q <= 1'b1;
                        end
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 32'd1;
                    end
                end
                S_RAMP:
                begin
                    if (ramp_done)
                    begin
                        state_q           <= S_RUN;
                        ramp_active_q     <= 1'b0;
                        soft_start_done_q <= 1'b1;
                    end
                end
                S_RUN:
                begin
                    // left only through the shutdown branch when go drops
                    state_q <= S_RUN;
                end
                default:
                begin
                    state_q <= S_OFF;
                end
            endcase
        end
    end

    // reference ramp: starts from the measured output so a pre-bias
    // is never pulled down before the rise
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dac_q         <= 8'h00;
            target_q      <= 8'h00;
            restore_cnt_q <= 32'h0000_0000;
        end
        else if (!run)
        begin
            dac_q         <= vout_measured;
            target_q      <= boot_target;
            restore_cnt_q <= 32'h0000_0000;
        end
        else
        begin
            if (vout_cmd_wr && !ext_ref_sel_q)
            begin
                target_q <= vout_cmd_data;
            end
            if (!psi_func_sel_q && power_good_flag && !boot_restore_n)
            begin
                if (restore_hit)
                begin
                    target_q <= boot_target;
                end
                else
                begin
                    restore_cnt_q <= restore_cnt_q + 32'd1;
                end
            end
            else
            begin
                restore_cnt_q <= 32'h0000_0000;
            end
            // one soft start step per strobe, also for restore
            if (soft_step)
            begin
                if (dac_q < target_q)
                begin
                    dac_q <= dac_q + 8'd1;
                end
                else if (dac_q > target_q)
                begin
                    dac_q <= dac_q - 8'd1;
                end
            end
        end
    end

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vout_read_q          <= 8'h00;
            single_phase_state_q <= 1'b0;
        end
        else
        begin
            // a fixed code tells the host the target is not in use
            vout_read_q <= ext_ref_sel_q ? `MPS_VOUT_READ_EXT
                                         : vout_measured;
            // shedding waits for power good so a pin that is still
            // settling during start-up cannot drop phases
            if (!run || !psi_func_sel_q)
            begin
                single_phase_state_q <= 1'b0;
            end
            else if (power_good_flag)
            begin
                single_phase_state_q <= ~psi_level;
            end
        end
    end
endmodule // mps_sequencer

/* File: tb/mps_sequencer_asserts.sv */
// port-level assertion checker for the phase sequencer
`timescale 1ns/1ps
module mps_sequencer_asserts #(
    parameter RST_CYC     = 20,
    parameter RESTORE_CYC = 30
) (
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic        enable_above_th,
    input wire logic        undervoltage_lockout,
    input wire logic        vcc_ok,
    input wire logic        driver_supply_ok,
    input wire logic        turn_on_delay_cmd_wr,
    input wire logic [15:0] turn_on_delay_cmd_data,
    input wire logic        vout_cmd_wr,
    input wire logic        power_good_flag,
    input wire logic [5:0]  pwm_hi_on_q,
    input wire logic [5:0]  pwm_lo_on_q,
    input wire logic [7:0]  target_q,
    input wire logic [7:0]  vout_read_q,
    input wire logic        ramp_active_q,
    input wire logic [2:0]  phase_count_q,
    input wire logic        prot_enable_q,
    input wire logic        ext_ref_sel_q,
    input wire logic        psi_func_sel_q,
    input wire logic        single_phase_state_q,
    input wire logic [15:0] turn_on_delay_cmd_q
);
    logic [31:0] up_cnt_q;
    // counts cycles since enable and supply were last both good
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            up_cnt_q <= 32'h0000_0000;
        else if (enable_above_th && !undervoltage_lockout && vcc_ok)
            up_cnt_q <= up_cnt_q + 32'h0000_0001;
        else
            up_cnt_q <= 32'h0000_0000;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_off;
        !enable_above_th || undervoltage_lockout;
    endsequence
    sequence s_float;
        pwm_hi_on_q == 6'h00 && pwm_lo_on_q == 6'h00;
    endsequence
    sequence s_running;
        ramp_active_q [*2];
    endsequence
    chk_off_float: assert property (s_off |=> s_float)
        else $error("outputs not floating after shutdown");
    chk_drv_float: assert property (!driver_supply_ok |=> s_float)
        else $error("outputs driven without driver supply");
    chk_no_short: assert property ((pwm_hi_on_q & pwm_lo_on_q) == 6'h00)
        else $error("both drive switches on");
    chk_phase_gate: assert property (s_running |->
        ((pwm_hi_on_q | pwm_lo_on_q) >> phase_count_q) == 6'h00)
        else $error("unused phase output driven");
    chk_one_phase: assert property (single_phase_state_q [*3] |->
        ((pwm_hi_on_q | pwm_lo_on_q) & 6'h3E) == 6'h00)
        else $error("single phase state drives other phases");
    chk_ton_write: assert property (turn_on_delay_cmd_wr |=>
        turn_on_delay_cmd_q == $past(turn_on_delay_cmd_data))
        else $error("turn-on delay not written");
    chk_ext_target: assert property (ext_ref_sel_q && vout_cmd_wr |=>
        $stable(target_q))
        else $error("target changed under external reference");
    chk_ext_read: assert property (ext_ref_sel_q [*3] |->
        vout_read_q == 8'hFF)
        else $error("readback not FFh under external reference");
    chk_ramp_wait: assert property ($rose(ramp_active_q) |->
        $past(driver_supply_ok) && up_cnt_q > RST_CYC + turn_on_delay_cmd_q)
        else $error("ramp started early");
    chk_strap_hold: assert property (s_running |-> $stable({
        phase_count_q, prot_enable_q, ext_ref_sel_q, psi_func_sel_q}))
        else $error("strap settings changed while running");
    chk_psi_power_good_flag: assert property ($rose(single_phase_state_q) |->
        $past(power_good_flag))
        else $error("power state changed before power good");
endmodule // mps_sequencer_asserts

bind mps_sequencer mps_sequencer_asserts #(.RST_CYC(RST_CYC),
    .RESTORE_CYC(RESTORE_CYC)) u_chk (.mclk, .arst_n, .enable_above_th,
    .undervoltage_lockout, .vcc_ok, .driver_supply_ok, .turn_on_delay_cmd_wr,
    .turn_on_delay_cmd_data, .vout_cmd_wr, .power_good_flag, .pwm_hi_on_q,
    .pwm_lo_on_q, .target_q, .vout_read_q, .ramp_active_q, .phase_count_q,
    .prot_enable_q, .ext_ref_sel_q, .psi_func_sel_q, .single_phase_state_q,
    .turn_on_delay_cmd_q);

/* File: tb/mps_driver_stage.sv */
// power stage model: resolves tri-level pins, reports its supply
`timescale 1ns/1ps
module mps_driver_stage (
    input  wire logic       mclk,
    input  wire logic       supply_on,
    input  wire logic [5:0] hi_on,
    input  wire logic [5:0] lo_on,
    output wire logic       driver_supply_ok,
    output wire logic [5:0] pin_high,
    output wire logic [5:0] pin_mid
);
    logic [2:0] ramp_q = 3'h0;
    // supply comes up a few cycles late but drops at once
    always @(posedge mclk)
        ramp_q <= supply_on ? {ramp_q[1:0], 1'b1} : 3'h0;
    assign driver_supply_ok = ramp_q[2];
    assign pin_high = hi_on & ~lo_on;
    // divider pulls an undriven pin to mid-level
    assign pin_mid = ~(hi_on | lo_on);
endmodule // mps_driver_stage

/* File: tb/mps_sequencer_test.sv */
// self-checking bench for the phase sequencer
`timescale 1ns/1ps
module mps_sequencer_test;
    localparam RST_CYC     = 20;
    localparam RESTORE_CYC = 30;
    localparam logic [23:0] ph_tab = 24'hDB_14E6;
    localparam logic [7:0]  prot_tab = 8'h0F, ovp_tab = 8'h0C;
    localparam logic [7:0]  flt_tab = 8'h1A, ext_tab = 8'hF0;
    localparam logic [7:0]  psi_tab = 8'hFC, tha_tab = 8'hE5;
    logic        mclk = 1'b0, arst_n = 1'b0, vcc_ok = 1'b0;
    logic        enable_above_th = 1'b0, undervoltage_lockout = 1'b0;
    logic        supply_on = 1'b0, turn_on_delay_cmd_wr = 1'b0, vout_cmd_wr = 1'b0;
    logic        ref_reached = 1'b0, soft_step = 1'b0;
    logic        power_good_flag = 1'b0, boot_restore_n = 1'b1;
    logic [2:0]  phase_strap = 3'h0, protection_strap = 3'h0;
    logic [2:0]  reference_strap = 3'h0;
    logic [15:0] turn_on_delay_cmd_data = 16'h0000;
    logic [7:0]  vout_cmd_data = 8'h00, boot_target = 8'h50;
    logic [7:0]  vout_measured = 8'h30;
    logic [5:0]  pwm_in = 6'h00;
    wire         driver_supply_ok, ramp_active_q, soft_start_done_q;
    wire         prot_enable_q, ovp_latch_q, fault_latch_q, ext_ref_sel_q;
    wire         psi_func_sel_q, thermal_option_a_q, single_phase_state_q;
    wire [5:0]   pin_high, pin_mid, pwm_hi_on_q, pwm_lo_on_q;
    wire [7:0]   target_q, dac_q, vout_read_q;
    wire [2:0]   phase_count_q;
    wire [15:0]  turn_on_delay_cmd_q;
    int          n_fail = 0, n_compared = 0, k;

    mps_sequencer #(.RST_CYC(RST_CYC), .RESTORE_CYC(RESTORE_CYC)) dut (
        .mclk, .arst_n, .enable_above_th, .undervoltage_lockout, .vcc_ok,
        .driver_supply_ok, .phase_strap, .protection_strap, .reference_strap,
        .turn_on_delay_cmd_wr, .turn_on_delay_cmd_data, .vout_cmd_wr, .vout_cmd_data,
        .boot_target, .vout_measured, .ref_reached, .soft_step,
        .power_good_flag, .boot_restore_n, .pwm_in, .pwm_hi_on_q,
        .pwm_lo_on_q, .target_q, .dac_q, .vout_read_q, .ramp_active_q,
        .soft_start_done_q, .phase_count_q, .prot_enable_q, .ovp_latch_q,
        .fault_latch_q, .ext_ref_sel_q, .psi_func_sel_q, .thermal_option_a_q,
        .single_phase_state_q, .turn_on_delay_cmd_q);
    mps_driver_stage model (.mclk, .supply_on, .hi_on(pwm_hi_on_q),
        .lo_on(pwm_lo_on_q), .driver_supply_ok, .pin_high, .pin_mid);

    initial
        forever #2.5 mclk = ~mclk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wait_ramp(input int lim);
        k = 0;
        while (ramp_active_q !== 1'b1 && k < lim)
        begin
            cyc(1);
            k++;
        end
    endtask
    task automatic ton_write(input logic [15:0] d);
        turn_on_delay_cmd_data = d;
        turn_on_delay_cmd_wr = 1'b1;
        cyc(1);
        turn_on_delay_cmd_wr = 1'b0;
    endtask
    task automatic vout_write(input logic [7:0] d);
        vout_cmd_data = d;
        vout_cmd_wr = 1'b1;
        cyc(1);
        vout_cmd_wr = 1'b0;
    endtask
    task automatic slew_step;
        soft_step = 1'b1;
        cyc(1);
        soft_step = 1'b0;
        cyc(1);
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // whole run is a few hundred cycles
    initial
    begin
        repeat (4000) @(posedge mclk);
        n_fail++;
        wrap_up;
    end

    initial
    begin
        cyc(3);
        arst_n = 1'b1;
        cyc(1);
        chk(phase_count_q, 16'h0006);
        chk(thermal_option_a_q, 16'h0001);
        chk(turn_on_delay_cmd_q, 16'h0000);
        // vcc low keeps the sequencer idle while straps are sampled
        enable_above_th = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            phase_strap = 3'(i);
            protection_strap = 3'(i);
            reference_strap = 3'(i);
            cyc(3);
            chk(phase_count_q, ph_tab[3*i +: 3]);
            chk(prot_enable_q, prot_tab[i]);
            chk(fault_latch_q, flt_tab[i]);
            if (i < 4)
                chk(ovp_latch_q, ovp_tab[i]);
            chk(ext_ref_sel_q, ext_tab[i]);
            chk(psi_func_sel_q, psi_tab[i]);
            chk(thermal_option_a_q, tha_tab[i]);
        end
        $display("strap test done");
        enable_above_th = 1'b0;
        phase_strap = 3'h1;
        protection_strap = 3'h0;
        reference_strap = 3'h0;
        ton_write(16'h0005);
        chk(turn_on_delay_cmd_q, 16'h0005);
        enable_above_th = 1'b1;
        vcc_ok = 1'b1;
        wait_ramp(RST_CYC + 20);
        chk(ramp_active_q, 16'h0000);
        chk(pin_mid, 16'h003F);
        supply_on = 1'b1;
        wait_ramp(20);
        chk(ramp_active_q, 16'h0001);
        chk(dac_q, 16'h0030);
        for (int s = 0; s < 64 && soft_start_done_q !== 1'b1; s++)
            slew_step;
        chk(soft_start_done_q, 16'h0001);
        chk(dac_q, 16'h0050);
        pwm_in = 6'h3F;
        cyc(2);
        chk(pin_high, 16'h000F);
        chk(pin_mid, 16'h0030);
        pwm_in = 6'h00;
        cyc(2);
        chk(pwm_lo_on_q, 16'h000F);
        vout_write(8'h40);
        cyc(1);
        chk(target_q, 16'h0040);
        slew_step;
        chk(dac_q, 16'h004F);
        boot_restore_n = 1'b0;
        cyc(RESTORE_CYC + 4);
        boot_restore_n = 1'b1;
        power_good_flag = 1'b1;
        cyc(1);
        chk(target_q, 16'h0040);
        boot_restore_n = 1'b0;
        cyc(RESTORE_CYC - 10);
        boot_restore_n = 1'b1;
        cyc(2);
        chk(target_q, 16'h0040);
        boot_restore_n = 1'b0;
        cyc(RESTORE_CYC + 4);
        chk(target_q, 16'h0050);
        slew_step;
        chk(dac_q, 16'h0050);
        boot_restore_n = 1'b1;
        enable_above_th = 1'b0;
        cyc(2);
        chk(pin_mid, 16'h003F);
        chk(ramp_active_q, 16'h0000);
        chk(soft_start_done_q, 16'h0000);
        $display("startup test done");
        power_good_flag = 1'b0;
        phase_strap = 3'h0;
        reference_strap = 3'h4;
        enable_above_th = 1'b1;
        wait_ramp(RST_CYC + 40);
        chk(k >= RST_CYC + 7 && k <= RST_CYC + 13, 16'h0001);
        vout_write(8'h22);
        cyc(2);
        chk(vout_read_q, 16'h00FF);
        chk(soft_start_done_q, 16'h0000);
        ref_reached = 1'b1;
        cyc(3);
        chk(soft_start_done_q, 16'h0001);
        pwm_in = 6'h3F;
        boot_restore_n = 1'b0;
        cyc(4);
        chk(single_phase_state_q, 16'h0000);
        chk(pwm_hi_on_q, 16'h003F);
        power_good_flag = 1'b1;
        cyc(4);
        chk(pwm_hi_on_q, 16'h0001);
        chk(pin_mid, 16'h003E);
        boot_restore_n = 1'b1;
        phase_strap = 3'h4;
        cyc(4);
        chk(pwm_hi_on_q, 16'h003F);
        chk(phase_count_q, 16'h0006);
        undervoltage_lockout = 1'b1;
        cyc(2);
        chk(pin_mid, 16'h003F);
        $display("reference test done");
        wrap_up;
    end
endmodule // mps_sequencer_test
